/* hw/pwmirq_defs.svh */
/*
 * Register offsets, field positions and reset values of the PWM unit interrupt block.
 * Assumes inclusion by bare name from design files.
 */
`ifndef PWMIRQ_DEFS_SVH
`define PWMIRQ_DEFS_SVH

`define PWMIRQ_OFS_ENABLES      12'h110
`define PWMIRQ_OFS_RAW          12'h114
`define PWMIRQ_OFS_MASKED       12'h118
`define PWMIRQ_OFS_CLEAR        12'h11c
`define PWMIRQ_RST_ENABLES      32'h00000000
`define PWMIRQ_RST_RAW          32'h00000000
`define PWMIRQ_NUM_SRC          30
// Field positions, lowest bit of each group of three
`define PWMIRQ_POS_TIMER_STOP   0
`define PWMIRQ_POS_TIMER_ZERO   3
`define PWMIRQ_POS_TIMER_PERIOD 6
`define PWMIRQ_POS_FAULT_START  9
`define PWMIRQ_POS_FAULT_END    12
`define PWMIRQ_POS_CMP_A        15
`define PWMIRQ_POS_CMP_B        18
`define PWMIRQ_POS_CBC_TRIP     21
`define PWMIRQ_POS_OST_TRIP     24
`define PWMIRQ_POS_CAPTURE      27

`endif

/* hw/pwmirq_pkg.sv */
/*
 * Types of the PWM unit interrupt block.
 * Assumes the defs header is compiled alongside.
 */
package pwmirq_pkg;

    // One bit per unit, unit 2 in the top bit
    typedef struct packed {
        logic [2:0] capture;
        logic [2:0] one_shot_trip;
        logic [2:0] cycle_by_cycle_trip;
        logic [2:0] operator_compare_b_event;
        logic [2:0] operator_compare_a_event;
        logic [2:0] fault_end;
        logic [2:0] fault_start;
        logic [2:0] timer_period_event;
        logic [2:0] timer_zero_event;
        logic [2:0] timer_stop;
    } pwmirq_events_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pwmirq_apb_req_type;

endpackage : pwmirq_pkg

/* hw/pwmirq_flag.sv */
/*
 * One sticky interrupt flag with its enable bit and masked view.
 * Assumes event, clear and enable come from logic on the same clock.
 */
`timescale 1ns/10ps

module pwmirq_flag (
    input  wire logic CORE_CLK,
    input  wire logic RESET,
    input  wire logic CLK_EN,
    input  wire logic event_in,
    input  wire logic clear_in,
    input  wire logic enable_in,
    output logic      raw_out,
    output logic      masked_out
);

    logic raw_r;

    // Event wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            raw_r <= 1'b0;
        end else if (CLK_EN) begin
            raw_r <= event_in | (raw_r & ~clear_in); // [RL15] [RL13]
        end
    end

    assign raw_out    = raw_r;
    assign masked_out = raw_r & enable_in; // [RL11]

endmodule : pwmirq_flag

/* hw/pwmirq_top.sv */
/*
 * Interrupt flag logic of a motor-control PWM unit, APB slave with four words.
 * Assumes event pulses are synchronous to CORE_CLK, one cycle each.
 */
// Decided for this implementation: the APB slave port.
// Behaviour
// RL1 - One raw flag per capture channel 0..2, set on capture.
// RL2 - One raw flag per PWM output 0..2, set on one-shot trip.
// RL3 - One raw flag per PWM output 0..2, set on cycle-by-cycle trip.
// RL4 - Per operator, separate raw flags for compare A and compare B events.
// RL5 - Per fault input, a raw flag set when the fault ends.
// RL6 - Per fault input, a separate raw flag set when the fault starts.
// RL7 - Per timer, raw flags for reaching zero and reaching period.
// RL8 - Per timer, a raw flag set when the timer stops.
// RL9 - Raw word at 0x114, read only, resets to zero, writes ignored.
// RL10 - Each source has its own read-write enable bit.
// RL11 - Masked bit equals raw flag AND enable bit.
// RL12 - Masked word at 0x118, read only.
// RL13 - Writing one to clear word 0x11c drops that raw flag; zero does nothing.
// RL14 - Enable word at 0x110, same bit positions as the others.
// RL15 - Raw flag sticky until cleared; event beats clear in same cycle.
// RL16 - Interrupt output high while any masked bit set; sources in bits 29..0.
`timescale 1ns/10ps
`include "pwmirq_defs.svh"

module pwmirq_top #(
    parameter int NUM_SRC = `PWMIRQ_NUM_SRC
) (
    input  wire logic                       CORE_CLK,
    input  wire logic                       RESET,
    input  wire logic                       CLK_EN,
    input  wire pwmirq_pkg::pwmirq_apb_req_type APB_REQ,
    output logic [31:0]                     PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    input  wire pwmirq_pkg::pwmirq_events_type EVENTS,
    output logic                            IRQ
);

    initial begin
        if (NUM_SRC != 30) begin
            $error("NUM_SRC must match the 30-bit event layout");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic        wr_en;
    logic        rd_en;
    logic        hit_ena;
    logic        hit_raw;
    logic        hit_mask;
    logic        hit_clr;
    logic        mapped;
    logic [31:0] ena_r;
    logic [31:0] ena_nxt;
    logic [31:0] prdata_r;
    logic [31:0] rd_nxt;
    logic [29:0] clr_vec;
    logic [29:0] evt_vec;
    logic [29:0] raw_vec;
    logic [29:0] mask_vec;

    // Single-cycle access phase: no wait states needed for flops
    assign PREADY  = 1'b1;
    assign hit_ena  = APB_REQ.paddr == `PWMIRQ_OFS_ENABLES;
    assign hit_raw  = APB_REQ.paddr == `PWMIRQ_OFS_RAW;
    assign hit_mask = APB_REQ.paddr == `PWMIRQ_OFS_MASKED;
    assign hit_clr  = APB_REQ.paddr == `PWMIRQ_OFS_CLEAR;
    assign mapped   = hit_ena | hit_raw | hit_mask | hit_clr;
    assign wr_en    = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & CLK_EN;
    assign rd_en    = APB_REQ.psel & ~APB_REQ.penable & ~APB_REQ.pwrite & CLK_EN;
    // Unmapped access answers with an error
    assign PSLVERR  = APB_REQ.psel & APB_REQ.penable & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // Enable register

    always_comb begin
        ena_nxt = ena_r;
        if (wr_en && hit_ena) begin
            ena_nxt = {2'h0, APB_REQ.pwdata[29:0]}; // [RL10] [RL14]
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ena_r <= `PWMIRQ_RST_ENABLES;
        end else if (CLK_EN) begin
            ena_r <= ena_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags

    // Only the clear word touches the flags; raw-word writes are dropped
    assign clr_vec = (wr_en && hit_clr) ? APB_REQ.pwdata[29:0] : 30'h0; // [RL13] [RL9]
    assign evt_vec = EVENTS; // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6] [RL7] [RL8] [RL16]

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
            pwmirq_flag u_flag (
                .CORE_CLK   (CORE_CLK),
                .RESET      (RESET),
                .CLK_EN     (CLK_EN),
                .event_in   (evt_vec[gi]),
                .clear_in   (clr_vec[gi]),
                .enable_in  (ena_r[gi]),
                .raw_out    (raw_vec[gi]),
                .masked_out (mask_vec[gi])
            );
        end
    endgenerate

    assign IRQ = |mask_vec; // [RL16]

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup cycle

    always_comb begin
        rd_nxt = 32'h0;
        if (hit_ena) begin
            rd_nxt = ena_r;
        end else if (hit_raw) begin
            rd_nxt = {2'h0, raw_vec}; // [RL9]
        end else if (hit_mask) begin
            rd_nxt = {2'h0, mask_vec}; // [RL12]
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            prdata_r <= 32'h0;
        end else if (rd_en) begin
            prdata_r <= rd_nxt;
        end
    end

    assign PRDATA = prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_clear_write(int b);
        wr_en && hit_clr && APB_REQ.pwdata[b];
    endsequence

    a_raw_sticky_set: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN && evt_vec[0] |=> raw_vec[0]) // [RL8]
        else $error("Raw flag 0 not set after event");
    a_event_beats_clear: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (CLK_EN && evt_vec[29]) and s_clear_write(29) |=> raw_vec[29]) // [RL15]
        else $error("Clear won over simultaneous event");
    a_clear_drops_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (CLK_EN && !evt_vec[5]) and s_clear_write(5) |=> !raw_vec[5]) // [RL13]
        else $error("Clear did not drop raw flag");
    // Each group from bit 3 up checked as a whole, so a swapped group position also fails
    a_capture_flags: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN |=> (raw_vec[29:27] & $past(evt_vec[29:27])) == $past(evt_vec[29:27])) // [RL1]
        else $error("Capture raw flag not set");
    a_oneshot_flags: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN |=> (raw_vec[26:24] & $past(evt_vec[26:24])) == $past(evt_vec[26:24])) // [RL2]
        else $error("One-shot trip raw flag not set");
    a_cbc_flags: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN |=> (raw_vec[23:21] & $past(evt_vec[23:21])) == $past(evt_vec[23:21])) // [RL3]
        else $error("Cycle-by-cycle trip raw flag not set");
    a_compare_flags: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN |=> (raw_vec[20:15] & $past(evt_vec[20:15])) == $past(evt_vec[20:15])) // [RL4]
        else $error("Compare raw flag not set");
    a_fault_end_flags: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN |=> (raw_vec[14:12] & $past(evt_vec[14:12])) == $past(evt_vec[14:12])) // [RL5]
        else $error("Fault end raw flag not set");
    a_fault_start_flags: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN |=> (raw_vec[11:9] & $past(evt_vec[11:9])) == $past(evt_vec[11:9])) // [RL6]
        else $error("Fault start raw flag not set");
    a_timer_flags: assert property (@(posedge CORE_CLK) disable iff (RESET)
        CLK_EN |=> (raw_vec[8:3] & $past(evt_vec[8:3])) == $past(evt_vec[8:3])) // [RL7]
        else $error("Timer zero or period raw flag not set");
    // Frozen clock enable must leave every flag as it was
    a_freeze_holds: assert property (@(posedge CORE_CLK) disable iff (RESET)
        !CLK_EN |=> raw_vec == $past(raw_vec))
        else $error("Raw flags changed while clock enable low");
    a_raw_holds_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
        raw_vec[12] && !(wr_en && hit_clr && APB_REQ.pwdata[12]) |=> raw_vec[12]) // [RL15]
        else $error("Raw flag dropped without clear");
    a_masked_gating: assert property (@(posedge CORE_CLK) disable iff (RESET)
        mask_vec == (raw_vec & ena_r[29:0])) // [RL11]
        else $error("Masked word differs from raw and enable");
    a_irq_level: assert property (@(posedge CORE_CLK) disable iff (RESET)
        IRQ == (mask_vec != 30'h0)) // [RL16]
        else $error("Interrupt level wrong");
    a_enable_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
        wr_en && hit_ena |=> ena_r == {2'h0, $past(APB_REQ.pwdata[29:0])}) // [RL10]
        else $error("Enable write not stored");
    a_raw_read_back: assert property (@(posedge CORE_CLK) disable iff (RESET)
        rd_en && hit_raw |=> PRDATA == {2'h0, $past(raw_vec)}) // [RL9]
        else $error("Raw read data wrong");
    a_masked_read: assert property (@(posedge CORE_CLK) disable iff (RESET)
        rd_en && hit_mask |=> PRDATA == {2'h0, $past(mask_vec)}) // [RL12]
        else $error("Masked read data wrong");

endmodule : pwmirq_top

/* dv/pwmirq_cpu_model.sv */
/* APB master that stands in for the processor core servicing the unit.
   Assumes pwmirq_pkg is compiled first and PRDATA is valid in the access phase. */
`timescale 1ns/10ps
module pwmirq_cpu_model (
    input  wire logic                      CORE_CLK,
    input  wire logic                      PREADY,
    input  wire logic [31:0]               PRDATA,
    input  wire logic                      PSLVERR,
    output pwmirq_pkg::pwmirq_apb_req_type req
);
    logic last_err = 1'b0;
    initial req = '0;
    ////////////////////////////////////////////////////////////////////////////
    // Request held until pready is seen high; clears are written as ones
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge CORE_CLK);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge CORE_CLK);
        req.penable <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        q = PRDATA;
        last_err = PSLVERR;
        req <= '0;
    endtask : xfer
endmodule : pwmirq_cpu_model

/* dv/test_pwm_unit_interrupt_status.sv */
/* Self-checking bench of the PWM unit interrupt block.
   Assumes the design files and the processor model are compiled first. */
`timescale 1ns/10ps
`include "pwmirq_defs.svh"
module test_pwm_unit_interrupt_status;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    pwmirq_pkg::pwmirq_events_type  ev  = '0;
    pwmirq_pkg::pwmirq_apb_req_type req;
    logic [31:0]                    rdata;
    logic                           ready;
    logic                           irq;
    logic                           slverr;
    logic                           en  = 1'b1;
    logic [31:0]                    q;
    int                             miscompares = 0;
    int                             n_checks    = 0;

    pwmirq_top u_pwmirq_top (.CORE_CLK(clk), .RESET(rst), .CLK_EN(en), .APB_REQ(req),
        .PRDATA(rdata), .PREADY(ready), .PSLVERR(slverr), .EVENTS(ev), .IRQ(irq));
    pwmirq_cpu_model u_pwmirq_cpu_model (.CORE_CLK(clk), .PREADY(ready), .PRDATA(rdata),
        .PSLVERR(slverr), .req(req));

    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        u_pwmirq_cpu_model.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_pwmirq_cpu_model.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic pulse(input logic [29:0] b);
        ev <= pwmirq_pkg::pwmirq_events_type'(b);
        @(posedge clk);
        ev <= '0;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(`PWMIRQ_OFS_ENABLES, 32'h0, "enables");
        rd(`PWMIRQ_OFS_RAW, 32'h0, "raw");
        rd(`PWMIRQ_OFS_RAW, 32'h0, "raw");
        chk("mapped err", 32'h0, {31'h0, u_pwmirq_cpu_model.last_err});
        rd(12'h120, 32'h0, "unmapped");
        chk("unmapped err", 32'h1, {31'h0, u_pwmirq_cpu_model.last_err});
        $display("reset test done");
    endtask : t_reset
    // Every source alone, so a swapped position shows up
    task automatic t_each();
        for (int i = 0; i < 30; i++) begin
            pulse(30'h1 << i);
            rd(`PWMIRQ_OFS_RAW, 32'h1 << i, "raw bit");
            chk("irq off", 32'h0, {31'h0, irq});
            wr(`PWMIRQ_OFS_CLEAR, 32'h1 << i);
            rd(`PWMIRQ_OFS_RAW, 32'h0, "cleared");
        end
        $display("source test done");
    endtask : t_each
    task automatic t_mask();
        wr(`PWMIRQ_OFS_ENABLES, 32'hffffffff);
        rd(`PWMIRQ_OFS_ENABLES, 32'h3fffffff, "enables all");
        wr(`PWMIRQ_OFS_ENABLES, 32'h2aaaaaaa);
        rd(`PWMIRQ_OFS_ENABLES, 32'h2aaaaaaa, "enables");
        pulse(30'h3fffffff);
        wr(`PWMIRQ_OFS_RAW, 32'h0);
        rd(`PWMIRQ_OFS_RAW, 32'h3fffffff, "raw kept");
        rd(`PWMIRQ_OFS_MASKED, 32'h2aaaaaaa, "masked");
        chk("irq on", 32'h1, {31'h0, irq});
        wr(`PWMIRQ_OFS_CLEAR, 32'h2aaaaaaa);
        rd(`PWMIRQ_OFS_RAW, 32'h15555555, "raw left");
        chk("irq off", 32'h0, {31'h0, irq});
        $display("mask test done");
    endtask : t_mask
    // Event lands at the very edge that takes the clear
    task automatic t_race();
        fork
            wr(`PWMIRQ_OFS_CLEAR, 32'h1);
            begin
                repeat (2) @(posedge clk);
                pulse(30'h1);
            end
        join
        rd(`PWMIRQ_OFS_RAW, 32'h15555555, "event wins");
        $display("race test done");
    endtask : t_race
    // Event while the clock enable is low must be lost
    task automatic t_freeze();
        en <= 1'b0;
        pulse(30'h2);
        en <= 1'b1;
        rd(`PWMIRQ_OFS_RAW, 32'h15555555, "frozen");
        $display("freeze test done");
    endtask : t_freeze
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_each();
        t_mask();
        t_race();
        t_freeze();
        complete_run();
    end
    // Whole run needs about 360 cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule : test_pwm_unit_interrupt_status
